// file: include/ppp_nvm_regs.vh
// Constants of the parallel programming port: codes, field positions,
// reset values and programming times.
// Assumes a 10 MHz system clock.
`ifndef PPP_NVM_REGS_VH
`define PPP_NVM_REGS_VH
// Action select codes
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3
// Command bytes
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEP 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEP 8'h03
// Address fields
`define PPP_FL_WORD_MSB 5
`define PPP_FL_PAGE_MSB 12
`define PPP_FL_PAGE_LSB 6
`define PPP_EE_WORD_MSB 1
`define PPP_EE_PAGE_MSB 8
`define PPP_EE_PAGE_LSB 2
`define PPP_SIG_LAST 8'h02
// Lock byte fields
`define PPP_LOCK_BASIC_MSB 1
`define PPP_LOCK_BOOT_MSB 5
`define PPP_LOCK_BOOT_LSB 2
// Reset values
`define PPP_FUSE_LO_RST 8'hFF
`define PPP_FUSE_HI_RST 8'hFF
`define PPP_FUSE_EXT_RST 8'hFF
`define PPP_LOCK_RST 8'hFF
// Programming times in microseconds, clock in MHz
`define PPP_CLK_MHZ 10
`define PPP_T_FLASH_US 2600
`define PPP_T_EEP_US 3600
`define PPP_T_FUSE_US 1000
`endif

// file: src/ppp_nvm_port.v
// Device side of the high-voltage parallel programming port, with the
// flash, EEPROM, fuse and lock storage it programs and reads back.
// Assumes every pin input is asynchronous to i_clk_sys and that strobes
// last several clock periods.
//
// Summary of operation
// RULE1: Action 10 crystal pulse loads command byte
// RULE2: Action 00 loads address low or high
// RULE3: Action 01 loads data low or high
// RULE4: Page-load pulse copies data word into buffer
// RULE5: Low address bits word, high bits page
// RULE6: Programmer fills buffer then loads address high
// RULE7: Write-low pulse programs page, busy until done
// RULE8: Command zero clears write controls
// RULE9: EEPROM page write by command 11
// RULE10: Flash read drives low or high byte
// RULE11: EEPROM read drives addressed byte
// RULE12: Fuse write selects low, high, extended
// RULE13: Lock write programs zero bits only
// RULE14: Lock mode 3 blocks boot lock programming
// RULE15: Lock bits never erased by lock write
// RULE16: Fuse and lock read by byte selects
// RULE17: Signature byte read at address 0 to 2
// RULE18: Calibration byte read with byte select one
// RULE19: Data bus driven only while output-enable low
// RULE20: Ready/busy low while programming
// RULE21: Programmer waits on busy, keeps output-enable high
`timescale 1ns/1ps
`include "ppp_nvm_regs.vh"
module ppp_nvm_port #(
  parameter T_FLASH_CYC = `PPP_T_FLASH_US * `PPP_CLK_MHZ,
  parameter T_EEP_CYC = `PPP_T_EEP_US * `PPP_CLK_MHZ,
  parameter T_FUSE_CYC = `PPP_T_FUSE_US * `PPP_CLK_MHZ,
  parameter [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary identity value
  parameter [7:0] SIG_BYTE1 = 8'hA5, // Arbitrary identity value
  parameter [7:0] SIG_BYTE2 = 8'h3C, // Arbitrary identity value
  parameter [7:0] CAL_BYTE = 8'h80 // Arbitrary calibration value
) (
  input wire i_clk_sys, // System clock
  input wire i_srst, // Synchronous reset, high
  input wire i_action_select_hi, // Action select bit 1
  input wire i_action_select_lo, // Action select bit 0
  input wire i_byte_select_first, // First byte select
  input wire i_byte_select_second, // Second byte select
  input wire i_crystal_load_strobe, // Load strobe, rising edge
  input wire i_page_load_strobe, // Page load, rising edge
  input wire i_write_n, // Write strobe, falling edge
  input wire i_out_enable_n, // Output enable, low
  input wire [7:0] i_data, // Data bus in
  output reg [7:0] o_data, // Data bus out
  output reg o_data_oe, // Data bus drive enable
  output reg o_ready_busy_out // 1 ready, 0 busy
);
  // ==========================================================
  // Pin synchronisers and edge detection
  // ==========================================================
  reg [15:0] sync1_q;
  reg [15:0] sync2_q;
  reg [15:0] sync3_q;
  wire [15:0] pins_raw = {i_data, i_action_select_hi, i_action_select_lo, i_byte_select_first,
    i_byte_select_second, i_crystal_load_strobe, i_page_load_strobe, i_write_n, i_out_enable_n};
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      sync1_q <= 16'h00FF;
      sync2_q <= 16'h00FF;
      sync3_q <= 16'h00FF;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  wire [7:0] data_s = sync2_q[15:8];
  wire [1:0] act_s = sync2_q[7:6];
  wire bs1_s = sync2_q[5];
  wire bs2_s = sync2_q[4];
  wire xtal_rise = sync2_q[3] & ~sync3_q[3];
  wire page_load_strobe_rise = sync2_q[2] & ~sync3_q[2];
  wire wr_fall = ~sync2_q[1] & sync3_q[1];
  wire oe_low = ~sync2_q[0];
  // ==========================================================
  // Storage
  // ==========================================================
  reg [15:0] flash_mem [0:8191];
  reg [7:0] eep_mem [0:511];
  reg [15:0] fl_pbuf [0:63];
  reg [7:0] ee_pbuf [0:3];
  reg [63:0] fl_mask_q;
  reg [3:0] ee_mask_q;
  reg [7:0] cmd_q;
  reg [7:0] addr_lo_q;
  reg [7:0] addr_hi_q;
  reg [7:0] dat_lo_q;
  reg [7:0] dat_hi_q;
  reg [7:0] fuse_lo_q;
  reg [7:0] fuse_hi_q;
  reg [7:0] fuse_ext_q;
  reg [7:0] lock_q;
  wire [15:0] addr = {addr_hi_q, addr_lo_q};
  // ==========================================================
  // Two-entry buffer between page-load pulses and page buffers
  // ==========================================================
  // Entry: {eeprom flag, word index, data word}
  reg [22:0] fifo_q [0:1];
  reg fifo_wp_q;
  reg fifo_rp_q;
  reg [1:0] fifo_cnt_q;
  wire fifo_full = (fifo_cnt_q == 2'h2);
  wire fifo_empty = (fifo_cnt_q == 2'h0);
  wire in_is_eep = (cmd_q == `PPP_CMD_WR_EEP);
  wire in_valid = page_load_strobe_rise;
  wire in_ready = ~fifo_full;
  wire out_valid = ~fifo_empty;
  wire [22:0] out_word = fifo_q[fifo_rp_q];
  reg busy_q;
  // Page buffers are frozen while a page is being programmed
  wire out_ready = ~busy_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      fifo_wp_q <= 1'b0;
      fifo_rp_q <= 1'b0;
      fifo_cnt_q <= 2'h0;
    end else begin
      if (push) begin
        // RULE4: capture held word
        fifo_q[fifo_wp_q] <= {in_is_eep, addr_lo_q[`PPP_FL_WORD_MSB:0], dat_hi_q, dat_lo_q};
        fifo_wp_q <= ~fifo_wp_q;
      end
      fifo_rp_q <= fifo_rp_q ^ pop;
      fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  // ==========================================================
  // Command decode helpers
  // ==========================================================
  function is_write_cmd;
    input [7:0] c;
    begin
      is_write_cmd = (c == `PPP_CMD_WR_FLASH) | (c == `PPP_CMD_WR_EEP) |
        (c == `PPP_CMD_WR_FUSE) | (c == `PPP_CMD_WR_LOCK);
    end
  endfunction
  // ==========================================================
  // Load registers, page buffers, programming sequencer
  // ==========================================================
  localparam ST_IDLE = 2'h0;
  localparam ST_PROG = 2'h1;
  localparam ST_DONE = 2'h2;
  reg [1:0] st_q;
  reg [31:0] cnt_q;
  reg [7:0] op_cmd_q;
  reg [1:0] op_fsel_q;
  reg [7:0] op_data_q;
  reg [6:0] op_page_q;
  reg [7:0] lock_new;
  integer i;
  // RULE14: boot lock held when mode 3
  // RULE15: only zero bits may be added
  always @* begin
    lock_new = lock_q & op_data_q;
    if (lock_q[`PPP_LOCK_BASIC_MSB:0] == 2'h0) begin
      lock_new[`PPP_LOCK_BOOT_MSB:`PPP_LOCK_BOOT_LSB] = lock_q[`PPP_LOCK_BOOT_MSB:`PPP_LOCK_BOOT_LSB];
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      cmd_q <= `PPP_CMD_NOP;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      dat_lo_q <= 8'h00;
      dat_hi_q <= 8'h00;
      fuse_lo_q <= `PPP_FUSE_LO_RST;
      fuse_hi_q <= `PPP_FUSE_HI_RST;
      fuse_ext_q <= `PPP_FUSE_EXT_RST;
      lock_q <= `PPP_LOCK_RST;
      fl_mask_q <= 64'h0;
      ee_mask_q <= 4'h0;
      st_q <= ST_IDLE;
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
      op_cmd_q <= `PPP_CMD_NOP;
      op_fsel_q <= 2'h0;
      op_data_q <= 8'h00;
      op_page_q <= 7'h00;
    end else begin
      if (xtal_rise & ~busy_q) begin
        case (act_s)
          // RULE1: command load
          `PPP_ACT_CMD: begin
            cmd_q <= data_s;
            // RULE8: nop ends the page session
            if (data_s == `PPP_CMD_NOP) begin
              fl_mask_q <= 64'h0;
              ee_mask_q <= 4'h0;
            end
          end
          // RULE2: address byte
          `PPP_ACT_ADDR: begin
            if (bs1_s) addr_hi_q <= data_s;
            else addr_lo_q <= data_s;
          end
          // RULE3: data byte
          `PPP_ACT_DATA: begin
            if (bs1_s) dat_hi_q <= data_s;
            else dat_lo_q <= data_s;
          end
          default: ;
        endcase
      end
      if (pop) begin
        // RULE5: low bits pick word
        if (out_word[22]) begin
          ee_pbuf[out_word[`PPP_EE_WORD_MSB + 16:16]] <= out_word[7:0];
          ee_mask_q[out_word[`PPP_EE_WORD_MSB + 16:16]] <= 1'b1;
        end else begin
          fl_pbuf[out_word[21:16]] <= out_word[15:0];
          fl_mask_q[out_word[21:16]] <= 1'b1;
        end
      end
      case (st_q)
        ST_IDLE: begin
          // RULE7: write-low starts programming
          if (wr_fall & is_write_cmd(cmd_q) & fifo_empty) begin
            st_q <= ST_PROG;
            busy_q <= 1'b1;
            op_cmd_q <= cmd_q;
            op_fsel_q <= {bs2_s, bs1_s};
            op_data_q <= dat_lo_q;
            // RULE5: page from high address bits
            if (cmd_q == `PPP_CMD_WR_EEP) begin
              op_page_q <= addr[`PPP_EE_PAGE_MSB:`PPP_EE_PAGE_LSB];
              cnt_q <= T_EEP_CYC;
            end else if (cmd_q == `PPP_CMD_WR_FLASH) begin
              op_page_q <= addr[`PPP_FL_PAGE_MSB:`PPP_FL_PAGE_LSB];
              cnt_q <= T_FLASH_CYC;
            end else begin
              op_page_q <= 7'h00;
              cnt_q <= T_FUSE_CYC;
            end
          end
        end
        ST_PROG: begin
          cnt_q <= cnt_q - 32'h1;
          if (cnt_q <= 32'h1) st_q <= ST_DONE;
        end
        ST_DONE: begin
          case (op_cmd_q)
            `PPP_CMD_WR_FLASH: begin
              for (i = 0; i < 64; i = i + 1) begin
                if (fl_mask_q[i]) begin
                  flash_mem[{op_page_q, i[5:0]}] <= fl_pbuf[i];
                end
              end
              fl_mask_q <= 64'h0;
            end
            // RULE9: eeprom page commit
            `PPP_CMD_WR_EEP: begin
              for (i = 0; i < 4; i = i + 1) begin
                if (ee_mask_q[i]) begin
                  eep_mem[{op_page_q, i[1:0]}] <= ee_pbuf[i];
                end
              end
              ee_mask_q <= 4'h0;
            end
            // RULE12: fuse target by selects
            `PPP_CMD_WR_FUSE: begin
              case (op_fsel_q)
                2'h0: fuse_lo_q <= op_data_q;
                2'h1: fuse_hi_q <= op_data_q;
                2'h2: fuse_ext_q <= op_data_q;
                default: ;
              endcase
            end
            // RULE13: lock write
            `PPP_CMD_WR_LOCK: lock_q <= lock_new;
            default: ;
          endcase
          st_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Read-back multiplexer and pin outputs
  // ==========================================================
  reg [7:0] rd_byte;
  reg [15:0] fl_word;
  always @* begin
    fl_word = flash_mem[addr[`PPP_FL_PAGE_MSB:0]];
    rd_byte = 8'hFF;
    case (cmd_q)
      // RULE10: flash byte by select
      `PPP_CMD_RD_FLASH: rd_byte = bs1_s ? fl_word[15:8] : fl_word[7:0];
      // RULE11: eeprom byte
      `PPP_CMD_RD_EEP: rd_byte = bs1_s ? 8'hFF : eep_mem[addr[`PPP_EE_PAGE_MSB:0]];
      // RULE16: fuse and lock map
      `PPP_CMD_RD_FUSE: begin
        case ({bs2_s, bs1_s})
          2'h0: rd_byte = fuse_lo_q;
          2'h3: rd_byte = fuse_hi_q;
          2'h2: rd_byte = fuse_ext_q;
          default: rd_byte = lock_q;
        endcase
      end
      `PPP_CMD_RD_SIG: begin
        // RULE18: calibration byte
        if (bs1_s) begin
          rd_byte = (addr_lo_q == 8'h00) ? CAL_BYTE : 8'hFF;
        // RULE17: signature bytes
        end else if (addr_lo_q <= `PPP_SIG_LAST) begin
          case (addr_lo_q[1:0])
            2'h0: rd_byte = SIG_BYTE0;
            2'h1: rd_byte = SIG_BYTE1;
            default: rd_byte = SIG_BYTE2;
          endcase
        end
      end
      default: rd_byte = 8'hFF;
    endcase
  end
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
      o_ready_busy_out <= 1'b1;
    end else begin
      // RULE19: drive only while enabled
      o_data_oe <= oe_low;
      o_data <= oe_low ? rd_byte : 8'h00;
      // RULE20: busy while programming
      o_ready_busy_out <= ~busy_q & ~fifo_full;
    end
  end
endmodule

// file: test/ppp_nvm_monitor.sv
// Pin-level checker for the parallel programming port.
// Bound to ppp_nvm_port, sees only its ports.
`timescale 1ns/1ps
`include "ppp_nvm_regs.vh"
module ppp_nvm_monitor #(
  parameter T_FLASH_CYC = 26000,
  parameter T_EEP_CYC = 36000,
  parameter T_FUSE_CYC = 10000
) (
  input wire i_clk_sys, // Clock
  input wire i_srst, // Reset
  input wire i_action_select_hi, // Action bit 1
  input wire i_action_select_lo, // Action bit 0
  input wire i_crystal_load_strobe, // Load strobe
  input wire i_write_n, // Write strobe
  input wire i_out_enable_n, // Output enable
  input wire [7:0] i_data, // Data in
  input wire [7:0] o_data, // Data out
  input wire o_data_oe, // Drive enable
  input wire o_ready_busy_out // Ready
);
  localparam T_A = T_FLASH_CYC < T_EEP_CYC ? T_FLASH_CYC : T_EEP_CYC;
  localparam T_B = T_FLASH_CYC < T_EEP_CYC ? T_EEP_CYC : T_FLASH_CYC;
  localparam T_MIN = T_A < T_FUSE_CYC ? T_A : T_FUSE_CYC;
  localparam T_MAX = T_B > T_FUSE_CYC ? T_B : T_FUSE_CYC;
  reg [7:0] cmd_q;
  reg xtal_q;
  reg [5:0] oe_sh_q;
  reg [7:0] wr_sh_q;
  integer busy_cnt_q;
  wire is_wr = cmd_q == `PPP_CMD_WR_FLASH || cmd_q == `PPP_CMD_WR_EEP ||
               cmd_q == `PPP_CMD_WR_FUSE || cmd_q == `PPP_CMD_WR_LOCK;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  // ==========
  // Helper state
  always @(posedge i_clk_sys) begin
    xtal_q <= i_crystal_load_strobe;
    oe_sh_q <= {oe_sh_q[4:0], ~i_out_enable_n};
    wr_sh_q <= {wr_sh_q[6:0], ~i_write_n};
    busy_cnt_q <= o_ready_busy_out ? 0 : busy_cnt_q + 1;
    if (i_srst) begin
      cmd_q <= `PPP_CMD_NOP;
    end else if (i_crystal_load_strobe && !xtal_q && o_ready_busy_out &&
                 {i_action_select_hi, i_action_select_lo} == `PPP_ACT_CMD) begin
      cmd_q <= i_data;
    end
  end
  // ==========
  // Assertions
  busy_start_a: assert property (
    $fell(i_write_n) && o_ready_busy_out && is_wr |-> ##[2:6] !o_ready_busy_out)
    else $error("busy did not follow write strobe");
  busy_len_a: assert property (
    $rose(o_ready_busy_out) |-> busy_cnt_q >= T_MIN + 1)
    else $error("busy too short");
  busy_max_a: assert property (busy_cnt_q <= T_MAX + 5)
    else $error("busy too long");
  busy_cause_a: assert property (
    $fell(o_ready_busy_out) |-> wr_sh_q != 8'h00)
    else $error("busy without write strobe");
  nop_idle_a: assert property (
    $fell(i_write_n) && o_ready_busy_out && cmd_q == `PPP_CMD_NOP |-> o_ready_busy_out[*8])
    else $error("write started after no-op");
  oe_on_a: assert property (!i_out_enable_n[*6] |-> o_data_oe)
    else $error("bus not driven during read");
  oe_off_a: assert property (o_data_oe |-> oe_sh_q != 6'h00)
    else $error("bus driven without output enable");
  data_idle_a: assert property (!o_data_oe |-> o_data == 8'h00)
    else $error("data not zero while released");
  reset_val_a: assert property ($past(i_srst) |-> o_ready_busy_out && !o_data_oe)
    else $error("bad state after reset");
endmodule
bind ppp_nvm_port ppp_nvm_monitor #(
  .T_FLASH_CYC(T_FLASH_CYC),
  .T_EEP_CYC(T_EEP_CYC),
  .T_FUSE_CYC(T_FUSE_CYC)
) u_mon (
  .i_clk_sys(i_clk_sys),
  .i_srst(i_srst),
  .i_action_select_hi(i_action_select_hi),
  .i_action_select_lo(i_action_select_lo),
  .i_crystal_load_strobe(i_crystal_load_strobe),
  .i_write_n(i_write_n),
  .i_out_enable_n(i_out_enable_n),
  .i_data(i_data),
  .o_data(o_data),
  .o_data_oe(o_data_oe),
  .o_ready_busy_out(o_ready_busy_out)
);

// file: test/ppp_prog_model.sv
// Model of the external parallel programmer driving the port pins.
// Pins change 10 ns after a rising edge; strobes last 4 clocks.
`timescale 1ns/1ps
module ppp_prog_model (
  input wire i_clk_sys, // Clock
  input wire [7:0] i_bus, // Resolved data bus
  input wire i_ready, // Ready from device
  output reg [1:0] o_act, // Action select pair
  output reg o_bs1, // First byte select
  output reg o_bs2, // Second byte select
  output reg o_xtal, // Load strobe
  output reg o_page_load_strobe, // Page load strobe
  output reg o_wr_n, // Write strobe
  output reg o_oe_n, // Output enable
  output reg [7:0] o_data // Programmer data
);
  initial begin
    o_act = 2'h3;
    {o_bs1, o_bs2, o_xtal, o_page_load_strobe} = 4'h0;
    {o_wr_n, o_oe_n} = 2'h3;
    o_data = 8'h00;
  end
  task wt(input integer n);
    repeat (n) @(posedge i_clk_sys);
    #10;
  endtask
  task ld(input [1:0] a, input b1, input [7:0] d);
    o_act = a;
    o_bs1 = b1;
    o_bs2 = 1'b0;
    o_data = d;
    wt(4);
    o_xtal = 1'b1;
    wt(4);
    o_xtal = 1'b0;
    wt(4);
  endtask
  task latch;
    o_page_load_strobe = 1'b1;
    wt(4);
    o_page_load_strobe = 1'b0;
    wt(4);
  endtask
  task wr(input b1, input b2);
    o_bs1 = b1;
    o_bs2 = b2;
    wt(4);
    o_wr_n = 1'b0;
    wt(4);
    o_wr_n = 1'b1;
    wt(8);
    while (!i_ready) wt(1);
    wt(4);
  endtask
  // Released line shows the inverse so stale data never reads back
  task rd(input b1, input b2, output [7:0] v);
    o_bs1 = b1;
    o_bs2 = b2;
    o_oe_n = 1'b0;
    o_data = ~o_data;
    wt(8);
    v = i_bus;
    o_oe_n = 1'b1;
    wt(6);
  endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the parallel programming port.
// Programmer model drives the pins; times shortened to 8 clocks.
`timescale 1ns/1ps
`include "ppp_nvm_regs.vh"
module tb_top;
  localparam [7:0] SIG0 = 8'h96; // Arbitrary
  localparam [7:0] SIG1 = 8'h69; // Arbitrary
  localparam [7:0] SIG2 = 8'h1E; // Arbitrary
  localparam [7:0] CAL = 8'h7B; // Arbitrary
  reg i_clk_sys = 1'b0;
  reg i_srst = 1'b1;
  integer busy_cnt = 0;
  integer busy_mark = 0;
  reg [7:0] v;
  wire [1:0] act;
  wire bs1, bs2, xtal, page_load_strobe, wr_n, oe_n, o_data_oe, o_ready_busy_out;
  wire [7:0] pdata, o_data, bus;
  integer errors = 0;
  integer comparisons = 0;
  integer i;
  assign bus = o_data_oe ? o_data : pdata;
  ppp_nvm_port #(.T_FLASH_CYC(8), .T_EEP_CYC(8), .T_FUSE_CYC(8), .SIG_BYTE0(SIG0),
    .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .CAL_BYTE(CAL)) i_ppp_nvm_port (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_action_select_hi(act[1]),
    .i_action_select_lo(act[0]), .i_byte_select_first(bs1), .i_byte_select_second(bs2),
    .i_crystal_load_strobe(xtal), .i_page_load_strobe(page_load_strobe), .i_write_n(wr_n),
    .i_out_enable_n(oe_n), .i_data(bus), .o_data(o_data), .o_data_oe(o_data_oe),
    .o_ready_busy_out(o_ready_busy_out));
  ppp_prog_model u_prog (.i_clk_sys(i_clk_sys), .i_bus(bus), .i_ready(o_ready_busy_out),
    .o_act(act), .o_bs1(bs1), .o_bs2(bs2), .o_xtal(xtal), .o_page_load_strobe(page_load_strobe),
    .o_wr_n(wr_n), .o_oe_n(oe_n), .o_data(pdata));
  initial forever #50 i_clk_sys = ~i_clk_sys;
  // ==========
  // Checking and closing
  task chk(input [7:0] seen, input [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task rdc(input b1, input b2, input [7:0] exp);
    u_prog.rd(b1, b2, v);
    chk(v, exp);
  endtask
  task busy(input exp);
    chk({7'h00, busy_cnt != busy_mark}, {7'h00, exp});
    busy_mark = busy_cnt;
  endtask
  task wl(input [7:0] d, input [7:0] exp);
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_LOCK);
    u_prog.ld(`PPP_ACT_DATA, 1'b0, d);
    u_prog.wr(1'b0, 1'b0);
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FUSE);
    rdc(1'b1, 1'b0, exp);
  endtask
  task finish_test;
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Busy cycles only counted here, so busy_cnt keeps a single driver
  always @(posedge i_clk_sys) begin
    if (!o_ready_busy_out) busy_cnt <= busy_cnt + 1;
  end
  // ==========
  // Main sequence
  task run_tests;
    repeat (4) @(posedge i_clk_sys);
    #10 i_srst = 1'b0;
    u_prog.wt(2);
    chk({7'h00, o_ready_busy_out}, 8'h01);
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FUSE);
    rdc(1'b0, 1'b0, `PPP_FUSE_LO_RST);
    rdc(1'b1, 1'b1, `PPP_FUSE_HI_RST);
    rdc(1'b0, 1'b1, `PPP_FUSE_EXT_RST);
    rdc(1'b1, 1'b0, `PPP_LOCK_RST);
    for (i = 0; i < 3; i = i + 1) begin
      u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FUSE);
      u_prog.ld(`PPP_ACT_DATA, 1'b0, 8'hA0 + i[7:0]);
      u_prog.wr(i == 1, i == 2);
      busy(1'b1);
    end
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FUSE);
    rdc(1'b0, 1'b0, 8'hA0);
    rdc(1'b1, 1'b1, 8'hA1);
    rdc(1'b0, 1'b1, 8'hA2);
    wl(8'hEF, 8'hEF);
    wl(8'hFC, 8'hEC);
    wl(8'hC3, 8'hEC);
    wl(8'hFF, 8'hEC);
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FLASH);
    for (i = 0; i < 2; i = i + 1) begin
      u_prog.ld(`PPP_ACT_ADDR, 1'b0, 8'h7E + i[7:0]);
      u_prog.ld(`PPP_ACT_DATA, 1'b0, 8'h11 + i[7:0]);
      u_prog.ld(`PPP_ACT_DATA, 1'b1, 8'h22 + i[7:0]);
      u_prog.latch;
    end
    u_prog.ld(`PPP_ACT_ADDR, 1'b1, 8'h01);
    busy_mark = busy_cnt;
    u_prog.wr(1'b0, 1'b0);
    busy(1'b1);
    // A word latched before the no-op must be dropped, not programmed
    u_prog.ld(`PPP_ACT_ADDR, 1'b0, 8'h7E);
    u_prog.ld(`PPP_ACT_DATA, 1'b0, 8'h55);
    u_prog.latch;
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_NOP);
    u_prog.wr(1'b0, 1'b0);
    busy(1'b0);
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FLASH);
    u_prog.wr(1'b0, 1'b0);
    busy(1'b1);
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FLASH);
    for (i = 0; i < 2; i = i + 1) begin
      u_prog.ld(`PPP_ACT_ADDR, 1'b0, 8'h7E + i[7:0]);
      rdc(1'b0, 1'b0, 8'h11 + i[7:0]);
      rdc(1'b1, 1'b0, 8'h22 + i[7:0]);
    end
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_EEP);
    u_prog.ld(`PPP_ACT_ADDR, 1'b1, 8'h00);
    u_prog.ld(`PPP_ACT_ADDR, 1'b0, 8'h05);
    u_prog.ld(`PPP_ACT_DATA, 1'b0, 8'hC3);
    u_prog.latch;
    u_prog.wr(1'b0, 1'b0);
    busy(1'b1);
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_EEP);
    rdc(1'b0, 1'b0, 8'hC3);
    u_prog.ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_SIG);
    for (i = 0; i < 3; i = i + 1) begin
      u_prog.ld(`PPP_ACT_ADDR, 1'b0, i[7:0]);
      rdc(1'b0, 1'b0, i == 0 ? SIG0 : i == 1 ? SIG1 : SIG2);
    end
    u_prog.ld(`PPP_ACT_ADDR, 1'b0, 8'h00);
    rdc(1'b1, 1'b0, CAL);
    chk({7'h00, o_data_oe}, 8'h00);
  endtask
  // A run that hangs counts one mismatch and ends in the same report
  initial begin
    fork
      run_tests;
      begin
        repeat (20000) @(posedge i_clk_sys);
        errors = errors + 1;
      end
    join_any
    finish_test;
  end
endmodule
